// File: src/prt_pkg.sv
// constants, types and register map of the prescaled reload timer
// assumes one 100 MHz clock and a byte-wide register port
package prt_pkg;

  // clock rate, kept for time conversions in this block
  localparam int unsigned PRT_CLK_HZ = 100_000_000;

  // register port widths
  localparam int PRT_AW = 16;
  localparam int PRT_DW = 8;

  // register offsets
  localparam logic [15:0] PRT_OFS_MODE = 16'h008B;
  localparam logic [15:0] PRT_OFS_PRE = 16'h008C;
  localparam logic [15:0] PRT_OFS_TMR = 16'h008D;
  localparam logic [15:0] PRT_OFS_SRC = 16'h008E;

  // field positions in timer_control_mode
  localparam int PRT_B_MOD0 = 0;
  localparam int PRT_B_MOD1 = 1;
  localparam int PRT_B_POL = 2;
  localparam int PRT_B_RUN = 3;
  localparam int PRT_B_INV = 4;
  localparam int PRT_B_MOD2 = 5;
  localparam int PRT_B_EDGE = 6;
  localparam int PRT_B_UND = 7;

  // values after reset
  localparam logic [7:0] PRT_RST_MODE = 8'h00;
  localparam logic [7:0] PRT_RST_CNT = 8'hFF;
  localparam logic [1:0] PRT_RST_SRC = 2'h0;
  localparam logic [7:0] PRT_RD_NONE = 8'h00;

  // count source codes
  localparam logic [1:0] PRT_SRC_F1 = 2'h0;
  localparam logic [1:0] PRT_SRC_F2 = 2'h1;
  localparam logic [1:0] PRT_SRC_F8 = 2'h2;
  localparam logic [1:0] PRT_SRC_LOSC = 2'h3;
  localparam logic [2:0] PRT_DIV8_LAST = 3'h7;

  // operating modes
  typedef enum logic [4:0] {
    PRT_M_TIMER = 5'b00001,
    PRT_M_PULSE = 5'b00010,
    PRT_M_EVENT = 5'b00100,
    PRT_M_WIDTH = 5'b01000,
    PRT_M_PERIOD = 5'b10000
  } prt_mode_t;

  // reload sequence of one stage for writes while running
  typedef enum logic [3:0] {
    PRT_S_IDLE = 4'b0001,
    PRT_S_STORE = 4'b0010,
    PRT_S_MOVE = 4'b0100,
    PRT_S_RESUME = 4'b1000
  } prt_seq_t;

  // one register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } prt_req_t;

endpackage

// File: src/prt_timer.sv
// prescaled reload timer: 8-bit prescaler feeding an 8-bit down counter
// assumes a same-clock register master; pins arrive asynchronously
//
// Functional notes
// - 8-bit timer behind 8-bit prescaler, each reloadable
// - reload and counter share one address
// - five modes selectable
// - timer mode decrements, reloads on underflow, continues
// - division is (prescale+1) times (timer+1)
// - writing run flag one starts counting
// - writing run flag zero halts counting
// - timer underflow raises timer interrupt
// - reads return live counter values
// - halted writes load reload and counter
// - running writes: store, move, resume on pulses
// - low mode bits 00 mean timer/period
// - upper mode bit zero excludes period mode
// - polarity bit picks external interrupt edge
// - polarity rewrite may raise external request
// - timer mode leaves pins as io/interrupt
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module prt_timer (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // register port
  input wire prt_pkg::prt_req_t req_in,
  output logic [7:0] rd_data_out,
  // pins
  input wire logic ext_int_pin_in,
  input wire logic low_speed_oscillator_clock_in,
  output logic counter_pin_out,
  output logic counter_pin_oe_out,
  // requests and status
  output logic timer_irq_out,
  output logic ext_irq_one_req_out,
  output prt_pkg::prt_mode_t mode_out
);
  import prt_pkg::*;

  // decode the three mode select bits into one mode
  function automatic prt_mode_t prt_decode(input logic [7:0] m);
    logic [2:0] sel;
    sel = {m[PRT_B_MOD2], m[PRT_B_MOD1], m[PRT_B_MOD0]};
    case (sel)
      3'h0: prt_decode = PRT_M_TIMER;
      3'h1: prt_decode = PRT_M_PULSE;
      3'h2: prt_decode = PRT_M_EVENT;
      3'h3: prt_decode = PRT_M_WIDTH;
      3'h4: prt_decode = PRT_M_PERIOD;
      default: prt_decode = PRT_M_TIMER;
    endcase
  endfunction

  // register state
  logic [7:0] mode_r; // timer_control_mode
  logic [1:0] src_sel_r; // count source select
  logic [7:0] pre_rld_r; // prescaler_reload_count
  logic [7:0] pre_cnt_r; // prescaler counter
  logic [7:0] tmr_rld_r; // timer reload
  logic [7:0] tmr_cnt_r; // timer counter
  logic [7:0] pre_data_r; // value held for running write
  logic [7:0] tmr_data_r;
  prt_seq_t pre_seq_r; // reload sequence per stage
  prt_seq_t tmr_seq_r;

  // count source generation
  logic [2:0] div_r; // free divider for f2 and f8
  logic losc_s1_r; // synchroniser, first stage
  logic losc_s2_r; // synchroniser, second stage
  logic losc_d_r; // delayed copy for edge detect
  logic src_tick_r; // one-cycle count source pulse

  // external interrupt input
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_act_r; // last active-level value

  // decoded controls
  logic run;
  logic timer_mode;
  logic wr_mode;
  logic wr_pre;
  logic wr_tmr;
  logic pre_uf;
  logic tmr_step;
  logic tmr_uf;
  logic ext_act;

  assign run = mode_r[PRT_B_RUN];
  assign timer_mode = (prt_decode(mode_r) == PRT_M_TIMER);
  assign wr_mode = req_in.wr && (req_in.addr == PRT_OFS_MODE);
  assign wr_pre = req_in.wr && (req_in.addr == PRT_OFS_PRE);
  assign wr_tmr = req_in.wr && (req_in.addr == PRT_OFS_TMR);
  // prescaler underflow only while its sequence is idle
  assign pre_uf = run && src_tick_r && (pre_seq_r == PRT_S_IDLE)
    && (pre_cnt_r == 8'h00);
  assign tmr_step = pre_uf && (tmr_seq_r == PRT_S_IDLE);
  assign tmr_uf = tmr_step && (tmr_cnt_r == 8'h00);
  // active level follows polarity at once, so a rewrite can fake an edge
  assign ext_act = ext_s2_r ^ mode_r[PRT_B_POL];

  // mode register; unused select bits are stored as written
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_r <= PRT_RST_MODE;
    end else if (wr_mode) begin
      mode_r <= req_in.wdata;
    end
  end

  // count source select register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_sel_r <= PRT_RST_SRC;
    end else if (req_in.wr && (req_in.addr == PRT_OFS_SRC)) begin
      src_sel_r <= req_in.wdata[1:0];
    end
  end

  // divider and low-speed oscillator synchroniser
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_r <= 3'h0;
      losc_s1_r <= 1'b0;
      losc_s2_r <= 1'b0;
      losc_d_r <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      losc_s1_r <= low_speed_oscillator_clock_in;
      losc_s2_r <= losc_s1_r;
      losc_d_r <= losc_s2_r;
    end
  end

  // selected count source pulse, one cycle wide
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_tick_r <= 1'b0;
    end else begin
      case (src_sel_r)
        PRT_SRC_F1: src_tick_r <= 1'b1;
        PRT_SRC_F2: src_tick_r <= div_r[0];
        PRT_SRC_F8: src_tick_r <= (div_r == PRT_DIV8_LAST);
        PRT_SRC_LOSC: src_tick_r <= losc_s2_r && !losc_d_r;
        default: src_tick_r <= 1'b0;
      endcase
    end
  end

  // prescaler stage: reload, counter and running-write sequence
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_rld_r <= PRT_RST_CNT;
      pre_cnt_r <= PRT_RST_CNT;
      pre_data_r <= PRT_RST_CNT;
      pre_seq_r <= PRT_S_IDLE;
    end else if (wr_pre && !run) begin
      pre_rld_r <= req_in.wdata;
      pre_cnt_r <= req_in.wdata;
      pre_seq_r <= PRT_S_IDLE;
    end else if (wr_pre) begin
      pre_data_r <= req_in.wdata;
      pre_seq_r <= PRT_S_STORE;
    end else if (!run && (pre_seq_r != PRT_S_IDLE)) begin
      // halted mid-sequence: finish the load at once
      pre_rld_r <= pre_data_r;
      pre_cnt_r <= pre_data_r;
      pre_seq_r <= PRT_S_IDLE;
    end else if (run && src_tick_r) begin
      case (pre_seq_r)
        PRT_S_STORE: begin
          pre_rld_r <= pre_data_r;
          pre_seq_r <= PRT_S_MOVE;
        end
        PRT_S_MOVE: begin
          pre_cnt_r <= pre_rld_r;
          pre_seq_r <= PRT_S_RESUME;
        end
        PRT_S_RESUME: pre_seq_r <= PRT_S_IDLE;
        PRT_S_IDLE: begin
          if (pre_cnt_r == 8'h00) begin
            pre_cnt_r <= pre_rld_r;
          end else begin
            pre_cnt_r <= pre_cnt_r - 8'h01;
          end
        end
        default: pre_seq_r <= PRT_S_IDLE;
      endcase
    end
  end

  // timer stage: steps on prescaler underflow, sequence on source pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tmr_rld_r <= PRT_RST_CNT;
      tmr_cnt_r <= PRT_RST_CNT;
      tmr_data_r <= PRT_RST_CNT;
      tmr_seq_r <= PRT_S_IDLE;
    end else if (wr_tmr && !run) begin
      tmr_rld_r <= req_in.wdata;
      tmr_cnt_r <= req_in.wdata;
      tmr_seq_r <= PRT_S_IDLE;
    end else if (wr_tmr) begin
      tmr_data_r <= req_in.wdata;
      tmr_seq_r <= PRT_S_STORE;
    end else if (!run && (tmr_seq_r != PRT_S_IDLE)) begin
      tmr_rld_r <= tmr_data_r;
      tmr_cnt_r <= tmr_data_r;
      tmr_seq_r <= PRT_S_IDLE;
    end else if (run && src_tick_r && (tmr_seq_r != PRT_S_IDLE)) begin
      case (tmr_seq_r)
        PRT_S_STORE: begin
          tmr_rld_r <= tmr_data_r;
          tmr_seq_r <= PRT_S_MOVE;
        end
        PRT_S_MOVE: begin
          tmr_cnt_r <= tmr_rld_r;
          tmr_seq_r <= PRT_S_RESUME;
        end
        PRT_S_RESUME: tmr_seq_r <= PRT_S_IDLE;
        default: tmr_seq_r <= PRT_S_IDLE;
      endcase
    end else if (tmr_uf) begin
      tmr_cnt_r <= tmr_rld_r;
    end else if (tmr_step) begin
      tmr_cnt_r <= tmr_cnt_r - 8'h01;
    end
  end

  // timer interrupt pulse, one cycle per underflow
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_irq_out <= 1'b0;
    end else begin
      timer_irq_out <= tmr_uf;
    end
  end

  // external interrupt pin synchroniser
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_int_pin_in;
      ext_s2_r <= ext_s1_r;
    end
  end

  // edge detect on active level; only the interrupt function in timer mode
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_act_r <= 1'b0;
      ext_irq_one_req_out <= 1'b0;
    end else begin
      ext_act_r <= ext_act;
      ext_irq_one_req_out <= timer_mode && ext_act && !ext_act_r;
    end
  end

  // dedicated counter pin stays plain io in timer mode: never driven here
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter_pin_out <= 1'b0;
      counter_pin_oe_out <= 1'b0;
    end else begin
      counter_pin_out <= 1'b0;
      counter_pin_oe_out <= 1'b0;
    end
  end

  // decoded mode published for the other mode blocks
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_out <= PRT_M_TIMER;
    end else begin
      mode_out <= prt_decode(mode_r);
    end
  end

  // read data, valid in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= PRT_RD_NONE;
    end else if (req_in.rd) begin
      case (req_in.addr)
        PRT_OFS_MODE: rd_data_out <= mode_r;
        PRT_OFS_PRE: rd_data_out <= pre_cnt_r;
        PRT_OFS_TMR: rd_data_out <= tmr_cnt_r;
        PRT_OFS_SRC: rd_data_out <= {6'h00, src_sel_r};
        default: rd_data_out <= PRT_RD_NONE;
      endcase
    end else begin
      rd_data_out <= PRT_RD_NONE;
    end
  end

endmodule

// File: bench/prt_pins.sv
// pin side model: external interrupt pin and slow oscillator
// assumes the bench sets the wanted pin level
`timescale 1ns/1ps
module prt_pins (
  // bench control
  input wire logic level_in,
  // pins toward the timer
  output logic ext_pin_out,
  output logic slow_clk_out
);
  // pin lags the bench, off the clock edge
  initial ext_pin_out = 1'b0;
  always @(level_in) ext_pin_out <= #3 level_in;
  // free running slow clock, 40 ns period
  initial slow_clk_out = 1'b0;
  always #20 slow_clk_out = ~slow_clk_out;
endmodule

// File: bench/prt_timer_monitor.sv
// port checks of the timer
// assumes one clock and the active low reset
`timescale 1ns/1ps
module prt_timer_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // register port
  input wire prt_pkg::prt_req_t req_in,
  input wire logic [7:0] rd_data_out,
  // pins
  input wire logic ext_int_pin_in,
  input wire logic low_speed_oscillator_clock_in,
  input wire logic counter_pin_out,
  input wire logic counter_pin_oe_out,
  // requests and status
  input wire logic timer_irq_out,
  input wire logic ext_irq_one_req_out,
  input wire prt_pkg::prt_mode_t mode_out
);
  import prt_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // mode register write seen at the port
  wire mode_wr = req_in.wr && req_in.addr == PRT_OFS_MODE;
  wire lo0 = req_in.wdata[1:0] == 2'h0;
  AST_PIN_OE: assert property (!counter_pin_oe_out)
    else $error("counter pin enabled");
  AST_PIN_LVL: assert property (!counter_pin_out)
    else $error("counter pin high");
  AST_RD_IDLE: assert property (!$past(req_in.rd) |-> !rd_data_out)
    else $error("read data outside slot");
  AST_RD_UNMAP: assert property (req_in.rd &&
    !(req_in.addr inside {[PRT_OFS_MODE:PRT_OFS_SRC]}) |=> !rd_data_out)
    else $error("unmapped read not zero");
  AST_MODE_TMR: assert property (mode_wr && lo0 && !req_in.wdata[5]
    |-> ##2 mode_out == PRT_M_TIMER) else $error("timer mode lost");
  AST_MODE_PER: assert property (mode_wr && lo0 && req_in.wdata[5]
    |-> ##2 mode_out == PRT_M_PERIOD) else $error("period mode lost");
  AST_EXT_ONE: assert property ($rose(ext_irq_one_req_out)
    |=> !ext_irq_one_req_out) else $error("ext request too long");
  AST_HALT: assert property (mode_wr && !req_in.wdata[PRT_B_RUN]
    ##1 !req_in.wr [*6] |-> !timer_irq_out) else $error("halted irq");
  // main scenarios reached
  cover property (timer_irq_out);
  cover property (ext_irq_one_req_out);
  cover property (mode_out == PRT_M_PERIOD);
endmodule

bind prt_timer prt_timer_monitor u_prt_timer_monitor (.clk_in, .nrst_in,
  .req_in, .rd_data_out, .ext_int_pin_in, .low_speed_oscillator_clock_in,
  .counter_pin_out, .counter_pin_oe_out, .timer_irq_out,
  .ext_irq_one_req_out, .mode_out);

// File: bench/prescaled_reload_timer_bench.sv
// self-checking bench of the timer
// assumes the pin model and the bound monitor
`timescale 1ns/1ps
module prescaled_reload_timer_bench;
  import prt_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  prt_req_t req = '0;
  logic [7:0] rd_data;
  logic lvl = 1'b0;
  logic ext_pin, slow_clk, tirq, eirq;
  prt_mode_t mode;
  int error_cnt = 0;
  int compares = 0;
  logic [15:0] lfsr = 16'h6961;
  int mdl[logic [15:0]];
  int div[4] = '{1, 2, 8, 4};
  int n, m, gap, k;
  logic [7:0] q;

  always #5 clk_in = ~clk_in;

  prt_timer u_prt_timer (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_in(req), .rd_data_out(rd_data), .ext_int_pin_in(ext_pin),
    .low_speed_oscillator_clock_in(slow_clk), .counter_pin_out(),
    .counter_pin_oe_out(), .timer_irq_out(tirq),
    .ext_irq_one_req_out(eirq), .mode_out(mode));
  prt_pins u_prt_pins (.level_in(lvl), .ext_pin_out(ext_pin),
    .slow_clk_out(slow_clk));

  // small random counts keep each period short
  function automatic int rnd4();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return int'(lfsr[1:0]);
  endfunction

  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  // one strobe; gap cycle after it avoids double drives
  task automatic bus(input logic [15:0] a, input logic [7:0] d,
      input logic w);
    @(posedge clk_in);
    req <= '{a, d, w, !w};
    @(posedge clk_in);
    req <= '0;
    #1 q = rd_data;
    if (w && a inside {[PRT_OFS_MODE:PRT_OFS_TMR]})
      mdl[a] = int'(d);
  endtask

  task automatic rdc(input logic [15:0] a);
    bus(a, 8'h00, 1'b0);
    chk({8'h00, q}, mdl.exists(a) ? 16'(mdl[a]) : 16'h0000);
  endtask

  // gap in cycles from the next timer pulse to the one after it
  task automatic measure();
    k = 0;
    while (tirq !== 1'b1 && k < 3000) begin
      step();
      k++;
    end
    gap = 0;
    do begin
      step();
      gap++;
    end while (tirq !== 1'b1 && gap < 3000);
    if (k >= 3000 || gap >= 3000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // pulses of the external request over the next 8 cycles
  task automatic count_ext();
    k = 0;
    repeat (8) begin
      step();
      if (eirq === 1'b1)
        k++;
    end
  endtask

  initial begin
    mdl[PRT_OFS_MODE] = 8'h00;
    mdl[PRT_OFS_PRE] = 8'hFF;
    mdl[PRT_OFS_TMR] = 8'hFF;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    rdc(PRT_OFS_MODE);
    rdc(PRT_OFS_TMR);
    bus(16'h0090, 8'h5A, 1'b1);
    rdc(16'h0090);
    bus(PRT_OFS_MODE, 8'h20, 1'b1);
    rdc(PRT_OFS_MODE);
    // every mode code once; unused select bits stay zero
    for (int c = 0; c < 5; c++) begin
      bus(PRT_OFS_MODE, c[2] ? 8'h20 : 8'(c), 1'b1);
      step();
      chk(16'(mode), 16'(1 << c));
    end
    bus(PRT_OFS_MODE, 8'h00, 1'b1);
    // every count source, random counts
    for (int s = 0; s < 4; s++) begin
      n = rnd4();
      m = rnd4();
      bus(PRT_OFS_SRC, 8'(s), 1'b1);
      bus(PRT_OFS_PRE, 8'(n), 1'b1);
      bus(PRT_OFS_TMR, 8'(m), 1'b1);
      rdc(PRT_OFS_PRE);
      rdc(PRT_OFS_TMR);
      bus(PRT_OFS_MODE, 8'h08, 1'b1);
      measure();
      measure();
      chk(16'(gap), 16'((n + 1) * (m + 1) * div[s]));
      // reload while running; old period may linger a while
      m = rnd4();
      bus(PRT_OFS_TMR, 8'(m), 1'b1);
      repeat (3) measure();
      chk(16'(gap), 16'((n + 1) * (m + 1) * div[s]));
      bus(PRT_OFS_MODE, 8'h00, 1'b1);
      repeat (20) step();
      n = rnd4();
      bus(PRT_OFS_PRE, 8'(n), 1'b1);
      repeat (20) step();
      rdc(PRT_OFS_PRE);
    end
    // both pin polarities, both edges
    for (int p = 0; p < 2; p++) begin
      // pin is low here, so falling polarity fakes one request
      bus(PRT_OFS_MODE, p[0] ? 8'h04 : 8'h00, 1'b1);
      count_ext();
      chk(16'(k), 16'(p[0]));
      repeat (2) begin
        @(posedge clk_in);
        lvl <= ~lvl;
        count_ext();
        chk(16'(k), 16'(lvl ^ p[0]));
      end
    end
    report_and_stop();
  end
endmodule
